// >>> include/flash_params.svh
/*
 Constants for the flash self-programming controller: register indexes, field positions,
 reset values, key values and timing figures.
 Assumes it is included by its bare name from the include directory.
*/
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// Register indexes; the bus byte address is four times the index.
`define IDX_OP_CONTROL 16'h0760
`define IDX_ADDR_LOW 16'h0762
`define IDX_ADDR_UPPER 16'h0764
`define IDX_UNLOCK_KEY 16'h0766
`define IDX_PAGE_POINTER 16'h0768

// Control register fields.
`define CON_WR_BIT 15
`define CON_WRITE_ENABLE_BIT_BIT 14
`define CON_WRITE_ERROR_FLAG_BIT 13
`define CON_WRITE_TERMINATE_FLAG_BIT 8
`define CON_ERASE_BIT 6
`define CON_TYPE_MSB 3
`define CON_TYPE_LSB 0
`define CON_OPSEL_MSB 6
`define CON_TYPE_MULTIWORD 4'h1
`define CON_RESET 16'h0000
`define ADDR_UPPER_RESET 8'h00

// Unlock key values.
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA

// Flash geometry: 32 words per row, 128 rows per panel.
`define ROW_WORDS 32
`define LAST_WORD_IDX 5'h1F
`define WORD_IDX_MSB 5
`define WORD_IDX_LSB 1
`define PANEL_LSB 13

// Table handshake phases.
`define PHASE_WRITE_DONE 2'h1
`define PHASE_READ_DONE 2'h2

// Operation time and clock period, and the cycle count derived from them.
`define OP_TIME_NS 2000000
`define CLK_PERIOD_NS 5
`define OP_CYCLES (`OP_TIME_NS / `CLK_PERIOD_NS)

`endif

// >>> include/flash_pkg.sv
/*
 Types used by the flash self-programming controller; its timer uses none of them.
 Assumes nothing of its surroundings.
*/
package flash_pkg;

   // Sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} seq_state_type;

   // Progress through the unlock key sequence.
   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_type;

endpackage : flash_pkg

// >>> include/op_timer_if.sv
/*
 Link between the sequencer and the operation timer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface op_timer_if;
   logic start;
   logic done;
   logic busy;

   modport ctrl (output start, input done, input busy);
   modport timer (input start, output done, output busy);
endinterface : op_timer_if

// >>> src/flash_op_timer.sv
/*
 Times one erase or program operation of the flash.
 Assumes start is a one-cycle pulse that arrives only while the timer is idle.
*/
`timescale 1ns/1ps

module flash_op_timer #(
   parameter int unsigned OP_CYCLES = 400000
) (
   input wire logic clk,
   input wire logic reset_n,
   op_timer_if.timer tif
);

   logic [31:0] count_q;
   logic busy_q;

   // The count runs down from the operation length less one to zero; done marks its last cycle.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count_q <= 32'h0000_0000;
         busy_q <= 1'b0;
      end else if (tif.start) begin
         count_q <= OP_CYCLES - 32'd1;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         if (count_q == 32'h0000_0000) begin
            busy_q <= 1'b0;
         end else begin
            count_q <= count_q - 32'd1;
         end
      end
   end

   assign tif.busy = busy_q;
   assign tif.done = busy_q && (count_q == 32'h0000_0000);

endmodule : flash_op_timer

// >>> src/flash_self_program_ctrl.sv
/*
 Run-time self-programming controller: table access through write latches, target
 address capture, unlock key and timed row erase or row program.
 Assumes an Avalon-MM master on the register port, a processor core on the table port
 and a flash macro whose read data follows flashAddr within the same cycle.
*/
`timescale 1ns/1ps
`include "flash_params.svh"

module flash_self_program_ctrl
   import flash_pkg::*;
#(
   parameter int unsigned OP_CYCLES = `OP_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic tableValid,
   input wire logic tableWrite,
   input wire logic tableHigh,
   input wire logic tableByte,
   input wire logic [15:0] effectiveAddr,
   input wire logic [15:0] tableWdata,
   output logic tableReady,
   output logic [15:0] tableRdata,
   output logic [23:0] flashAddr,
   input wire logic [23:0] flashRdata,
   output logic flashErase,
   output logic flashWordValid,
   output logic [4:0] flashWordIdx,
   output logic [23:0] flashWordData,
   output logic cpuStall
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Byte address of a register from its index.
   function automatic logic [15:0] regAddr(input logic [15:0] idx);
      regAddr = {idx[13:0], 2'b00};
   endfunction : regAddr

   // Merge the two low byte lanes of a bus write into a 16-bit register.
   function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
                                              input logic [3:0] be);
      mergeLanes = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
   endfunction : mergeLanes

   // Pick the table read data out of a 24-bit program word.
   function automatic logic [15:0] readSel(input logic [23:0] word, input logic high,
                                           input logic byteMode, input logic odd);
      if (high) begin
         readSel = (byteMode && odd) ? 16'h0000 : {8'h00, word[23:16]};
      end else if (byteMode) begin
         readSel = {8'h00, odd ? word[15:8] : word[7:0]};
      end else begin
         readSel = word[15:0];
      end
   endfunction : readSel

   ////////////////////////////////////////////////////////////////////////////////////////
   // State.

   logic ackQ;
   logic [31:0] readdataQ;
   logic wrAcc;
   logic conWrQ, conWrenQ, conErrQ;
   logic [6:0] conOpQ;
   logic [15:0] addrLowQ;
   logic [7:0] addrUpperQ;
   logic [7:0] pageQ;
   key_state_type keyStageQ;
   seq_state_type stateQ;
   logic [1:0] phaseQ;
   logic [23:0] latchQ [`ROW_WORDS];
   logic [10:0] latchPanelQ;
   logic [4:0] idxQ;
   logic flashEraseQ;
   logic [23:0] flashAddrQ;
   logic [15:0] tableRdataQ;
   logic [15:0] conNew;
   logic conHit, keyHit, startReq, startOp, busy;
   logic [23:0] target;
   op_timer_if tif ();

   flash_op_timer #(
      .OP_CYCLES(OP_CYCLES)
   ) opTimer (
      .clk(clk),
      .reset_n(reset_n),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: every access waits exactly one cycle, then completes.

   // A request is held off for one cycle so read data can come from a flip-flop.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ackQ <= 1'b0;
      end else begin
         ackQ <= (read || write) && !ackQ;
      end
   end

   assign waitrequest = (read || write) && !ackQ;
   assign wrAcc = write && ackQ;
   assign conHit = (address == regAddr(`IDX_OP_CONTROL));
   assign keyHit = (address == regAddr(`IDX_UNLOCK_KEY));
   assign conNew = mergeLanes({conWrQ, conWrenQ, conErrQ, 4'h0, 1'b0, 1'b0, conOpQ},
                              writedata, byteenable);

   // Read data is latched in the waiting cycle; the key and unmapped addresses read zero.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         readdataQ <= 32'h0000_0000;
      end else if (read && !ackQ) begin
         if (conHit) begin
            readdataQ <= {16'h0000, conWrQ, conWrenQ, conErrQ, 4'h0, 1'b0, 1'b0, conOpQ};
         end else if (address == regAddr(`IDX_ADDR_LOW)) begin
            readdataQ <= {16'h0000, addrLowQ};
         end else if (address == regAddr(`IDX_ADDR_UPPER)) begin
            readdataQ <= {24'h00_0000, addrUpperQ};
         end else if (address == regAddr(`IDX_PAGE_POINTER)) begin
            readdataQ <= {24'h00_0000, pageQ};
         end else begin
            readdataQ <= 32'h0000_0000;
         end
      end
   end

   assign readdata = readdataQ;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Unlock key and start decision.

   // Any write other than the expected next key byte breaks the sequence, so the two
   // key writes must be back to back on the bus.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         keyStageQ <= KEY_IDLE;
      end else if (wrAcc) begin
         if (keyHit && byteenable[0] && writedata[7:0] == `KEY_FIRST) begin
            keyStageQ <= KEY_GOT_FIRST;
         end else if (keyHit && byteenable[0] && writedata[7:0] == `KEY_SECOND &&
                      keyStageQ == KEY_GOT_FIRST) begin
            keyStageQ <= KEY_ARMED;
         end else begin
            keyStageQ <= KEY_IDLE;
         end
      end
   end

   assign busy = (stateQ != ST_IDLE);
   assign target = {addrUpperQ, addrLowQ};
   assign startReq = wrAcc && conHit && byteenable[1] && conNew[`CON_WR_BIT] && !busy;
   // Start needs enable, a multi-word type, the armed key and, for a program, latches
   // loaded inside the target's panel.
   assign startOp = startReq && conNew[`CON_WRITE_ENABLE_BIT_BIT] && keyStageQ == KEY_ARMED &&
                    conNew[`CON_TYPE_MSB:`CON_TYPE_LSB] == `CON_TYPE_MULTIWORD &&
                    (conNew[`CON_ERASE_BIT] ||
                     latchPanelQ == target[23:`PANEL_LSB]);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Control register.

   // Software writes the fields while idle; the start bit only ever rises through a valid
   // start and falls when the operation ends. A refused start raises the error flag,
   // which wins over a clear in the same write.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         {conWrQ, conWrenQ, conErrQ} <= 3'b000;
         conOpQ <= 7'(`CON_RESET);
      end else begin
         if (wrAcc && conHit && !busy) begin
            conWrenQ <= conNew[`CON_WRITE_ENABLE_BIT_BIT];
            conErrQ <= conNew[`CON_WRITE_ERROR_FLAG_BIT] || (startReq && !startOp);
            conOpQ <= conNew[`CON_OPSEL_MSB:0];
         end
         if (startOp) begin
            conWrQ <= 1'b1;
         end else if (tif.done) begin
            conWrQ <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer: erase goes straight to the timed wait, program streams the row first.

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stateQ <= ST_IDLE;
         idxQ <= 5'h00;
         flashEraseQ <= 1'b0;
      end else begin
         flashEraseQ <= 1'b0;
         case (stateQ)
            ST_IDLE: begin
               idxQ <= 5'h00;
               if (startOp && conNew[`CON_ERASE_BIT]) begin
                  flashEraseQ <= 1'b1;
                  stateQ <= ST_WAIT;
               end else if (startOp) begin
                  stateQ <= ST_STREAM;
               end
            end
            ST_STREAM: begin
               idxQ <= idxQ + 5'h01;
               if (idxQ == `LAST_WORD_IDX) begin
                  stateQ <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (tif.done) begin
                  stateQ <= ST_IDLE;
               end
            end
            default: begin
               stateQ <= ST_IDLE;
            end
         endcase
      end
   end

   // The timer starts with an erase, or in the same cycle as the last latch word is handed over.
   assign tif.start = (startOp && conNew[`CON_ERASE_BIT]) ||
                      (stateQ == ST_STREAM && idxQ == `LAST_WORD_IDX);
   assign cpuStall = busy;
   assign flashErase = flashEraseQ;
   assign flashWordValid = (stateQ == ST_STREAM);
   assign flashWordIdx = idxQ;
   assign flashWordData = latchQ[idxQ];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Table port: writes finish in two cycles, reads in three; refused while stalled.

   assign tableReady = tableValid && !busy &&
                       phaseQ == (tableWrite ? `PHASE_WRITE_DONE : `PHASE_READ_DONE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         phaseQ <= 2'h0;
      end else if (tableReady || !tableValid) begin
         phaseQ <= 2'h0;
      end else if (!busy) begin
         phaseQ <= phaseQ + 2'h1;
      end
   end

   // Address registers: a table access captures its address in its first cycle, a bus
   // write in the same cycle takes precedence.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         addrLowQ <= 16'h0000;
         addrUpperQ <= `ADDR_UPPER_RESET;
         pageQ <= 8'h00;
      end else begin
         if (tableValid && !busy && phaseQ == 2'h0) begin
            addrLowQ <= effectiveAddr;
            addrUpperQ <= pageQ;
         end
         if (wrAcc && address == regAddr(`IDX_ADDR_LOW)) begin
            addrLowQ <= mergeLanes(addrLowQ, writedata, byteenable);
         end
         if (wrAcc && address == regAddr(`IDX_ADDR_UPPER) && byteenable[0]) begin
            addrUpperQ <= writedata[7:0];
         end
         if (wrAcc && address == regAddr(`IDX_PAGE_POINTER) && byteenable[0]) begin
            pageQ <= writedata[7:0];
         end
      end
   end

   // The flash address follows a table access, or points at the target row at a start.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flashAddrQ <= 24'h00_0000;
      end else if (startOp) begin
         flashAddrQ <= {target[23:`WORD_IDX_MSB + 1], 6'h00};
      end else if (tableValid && !busy && phaseQ == 2'h0) begin
         flashAddrQ <= {pageQ, effectiveAddr};
      end
   end

   assign flashAddr = flashAddrQ;

   // Read data is taken one cycle after the address has reached the flash.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tableRdataQ <= 16'h0000;
      end else if (tableValid && !tableWrite && !busy && phaseQ == `PHASE_WRITE_DONE) begin
         tableRdataQ <= readSel(flashRdata, tableHigh, tableByte, effectiveAddr[0]);
      end
   end

   assign tableRdata = tableRdataQ;

   // Latch loads touch only the latches; the high half keeps the low source byte, and
   // the odd byte of the high half does not exist.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         latchPanelQ <= 11'h000;
         for (int i = 0; i < `ROW_WORDS; i++) begin
            latchQ[i] <= 24'hFF_FFFF;
         end
      end else if (tableReady && tableWrite) begin
         latchPanelQ <= {pageQ, effectiveAddr[15:`PANEL_LSB]};
         if (tableHigh && !(tableByte && effectiveAddr[0])) begin
            latchQ[effectiveAddr[`WORD_IDX_MSB:`WORD_IDX_LSB]][23:16] <= tableWdata[7:0];
         end else if (!tableHigh && tableByte && effectiveAddr[0]) begin
            latchQ[effectiveAddr[`WORD_IDX_MSB:`WORD_IDX_LSB]][15:8] <= tableWdata[7:0];
         end else if (!tableHigh && tableByte) begin
            latchQ[effectiveAddr[`WORD_IDX_MSB:`WORD_IDX_LSB]][7:0] <= tableWdata[7:0];
         end else if (!tableHigh) begin
            latchQ[effectiveAddr[`WORD_IDX_MSB:`WORD_IDX_LSB]][15:0] <= tableWdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   start_needs_key_a: assert property ($rose(conWrQ) |-> $past(keyStageQ) == KEY_ARMED)
      else $error("Operation started without the unlock key.");
   refused_start_a: assert property (startReq && keyStageQ != KEY_ARMED |=> !conWrQ && conErrQ)
      else $error("Start without key was not refused.");
   op_stalls_a: assert property (conWrQ |-> cpuStall)
      else $error("Core not stalled during an operation.");
   wr_autoclear_a: assert property (tif.done |=> !conWrQ && !cpuStall)
      else $error("Start bit not cleared at the end of an operation.");
   timer_runs_a: assert property (tif.start |=> tif.busy && conWrQ)
      else $error("Timer did not start with the operation.");
   stream_first_a: assert property ($rose(flashWordValid) |-> flashWordIdx == 5'h00)
      else $error("Row stream did not start at word zero.");
   stream_last_a: assert property ($fell(flashWordValid) |-> $past(flashWordIdx) == 5'h1F)
      else $error("Row stream did not cover 32 words.");
   latch_two_cycle_a: assert property (tableValid && tableWrite && !busy && phaseQ == 2'h0 &&
                                       !startOp |=> tableReady)
      else $error("Latch load did not finish in two cycles.");
   low_capture_a: assert property (tableReady && tableWrite && !$past(wrAcc) |->
                                   addrLowQ == effectiveAddr && addrUpperQ == pageQ)
      else $error("Address registers did not capture the table address.");
   high_byte_a: assert property (tableReady && tableWrite && tableHigh && !tableByte |=>
                                 latchQ[$past(effectiveAddr[5:1])][23:16] ==
                                 $past(tableWdata[7:0]))
      else $error("High word write stored the wrong byte.");

endmodule : flash_self_program_ctrl

// >>> verif/flash_model.sv
/*
 Behavioural model of the program flash macro that faces the controller.
 Assumes flashAddr holds the row base while a row is erased or streamed.
*/
`timescale 1ns/1ps

module flash_model (
   input wire logic clk,
   input wire logic [23:0] flashAddr,
   input wire logic flashErase,
   input wire logic flashWordValid,
   input wire logic [4:0] flashWordIdx,
   input wire logic [23:0] flashWordData,
   output logic [23:0] flashRdata
);
   logic [23:0] mem [logic [23:0]];
   int updates = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // An erase sets the whole row to ones; streamed words land at their row index.
   always @(posedge clk) begin
      if (flashErase === 1'b1) begin
         for (int i = 0; i < 32; i++) mem[{flashAddr[23:6], 5'(i), 1'b0}] = 24'hFFFFFF;
      end
      if (flashWordValid === 1'b1) mem[{flashAddr[23:6], flashWordIdx, 1'b0}] = flashWordData;
      updates++;
   end

   // Unwritten words read as the inverse of their address, so stale data never matches.
   // An odd byte address reads the word it lies in, as a byte table access expects.
   always @(flashAddr, updates) begin
      flashRdata = mem.exists({flashAddr[23:1], 1'b0}) ? mem[{flashAddr[23:1], 1'b0}] :
                   ~flashAddr;
   end
endmodule : flash_model

// >>> verif/flash_self_program_ctrl_bench.sv
/*
 Self-checking bench for the flash self-programming controller.
 Assumes flash_pkg, flash_params.svh and flash_model are compiled beside it.
*/
`timescale 1ns/1ps
`include "flash_params.svh"

module flash_self_program_ctrl_bench;
   localparam int OPC = 20;
   localparam logic [15:0] A_CON = 16'(`IDX_OP_CONTROL * 4);
   localparam logic [15:0] A_LOW = 16'(`IDX_ADDR_LOW * 4);
   localparam logic [15:0] A_UP = 16'(`IDX_ADDR_UPPER * 4);
   localparam logic [15:0] A_KEY = 16'(`IDX_UNLOCK_KEY * 4);
   localparam logic [15:0] A_PAGE = 16'(`IDX_PAGE_POINTER * 4);
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] address = 16'h0000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic tableValid = 1'b0;
   logic tableWrite = 1'b0;
   logic tableHigh = 1'b0;
   logic tableByte = 1'b0;
   logic [15:0] effectiveAddr = 16'h0000;
   logic [15:0] tableWdata = 16'h0000;
   logic tableReady;
   logic [15:0] tableRdata;
   logic [23:0] flashAddr;
   logic [23:0] flashRdata;
   logic flashErase;
   logic flashWordValid;
   logic [4:0] flashWordIdx;
   logic [23:0] flashWordData;
   logic cpuStall;
   int errors = 0;
   int checks_done = 0;
   int seed = 32'h68678AB6;
   int stallCnt = 0;
   int eraseCnt = 0;
   int wordCnt = 0;
   int n;
   int s;
   int e;
   int w;
   logic [15:0] q;
   logic [23:0] img [32];
   logic [7:0] page;
   logic [15:0] base;

   always #2.5 clk = ~clk;

   flash_self_program_ctrl #(.OP_CYCLES(OPC)) i_flash_self_program_ctrl (
      .clk(clk), .reset_n(reset_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .tableValid(tableValid), .tableWrite(tableWrite),
      .tableHigh(tableHigh), .tableByte(tableByte), .effectiveAddr(effectiveAddr),
      .tableWdata(tableWdata), .tableReady(tableReady), .tableRdata(tableRdata),
      .flashAddr(flashAddr), .flashRdata(flashRdata), .flashErase(flashErase),
      .flashWordValid(flashWordValid), .flashWordIdx(flashWordIdx),
      .flashWordData(flashWordData), .cpuStall(cpuStall));

   flash_model i_flash_model (
      .clk(clk), .flashAddr(flashAddr), .flashErase(flashErase),
      .flashWordValid(flashWordValid), .flashWordIdx(flashWordIdx),
      .flashWordData(flashWordData), .flashRdata(flashRdata));

   // Counts stall cycles, erase pulses and streamed words for the operation checks.
   always @(posedge clk) begin
      if (cpuStall === 1'b1) stallCnt++;
      if (flashErase === 1'b1) eraseCnt++;
      if (flashWordValid === 1'b1) wordCnt++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // Expected byte read: lanes 0 to 2 of the word by offset; the odd high byte reads zero.
   function automatic logic [23:0] byte_exp(input logic [23:0] wd, input int b);
      byte_exp = (b == 3) ? 24'h000000 : {16'h0000, 8'(wd >> (8 * b))};
   endfunction : byte_exp

   // One bus access; the request stands until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
      int k;
      k = 0;
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= {16'h0000, d};
      byteenable <= (a == A_CON || a == A_LOW) ? 4'h3 : 4'h1;
      do begin
         @(negedge clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 40);
      if (k >= 40) begin
         errors++;
         give_verdict();
      end
      // Read data stands in the cycle whose closing edge completes the access.
      q = readdata[15:0];
      @(posedge clk);
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic unlock();
      wr(A_KEY, 16'h0055);
      wr(A_KEY, 16'h00AA);
   endtask : unlock

   // One table access from the core; the long bound lets a stalled request wait.
   task automatic tbl(input logic wt, input logic h, input logic [15:0] ea,
                      input logic [15:0] d);
      n = 0;
      tableValid <= 1'b1;
      tableWrite <= wt;
      tableHigh <= h;
      effectiveAddr <= ea;
      tableWdata <= d;
      do begin
         @(negedge clk);
         n++;
      end while (tableReady !== 1'b1 && n < 200);
      if (n >= 200) begin
         errors++;
         give_verdict();
      end
      q = tableRdata;
      @(posedge clk);
      tableValid <= 1'b0;
      @(posedge clk);
   endtask : tbl

   // Reads back the whole row in both halves against the image.
   task automatic row_check();
      for (int i = 0; i < 32; i++) begin
         tbl(1'b0, 1'b0, base + 16'(2 * i), 16'h0000);
         check({8'h00, q}, {8'h00, img[i][15:0]});
         tbl(1'b0, 1'b1, base + 16'(2 * i), 16'h0000);
         check({8'h00, q}, {16'h0000, img[i][23:16]});
      end
   endtask : row_check

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, refused starts, erase, latch load and program.
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, A_CON, 16'h0000);
      check({8'h00, q}, 24'h000000);
      bus(1'b0, A_KEY, 16'h0000);
      check({8'h00, q}, 24'h000000);
      page = 8'($random(seed));
      base = 16'($random(seed)) & 16'hFFC0;
      wr(A_PAGE, {8'h00, page});
      tbl(1'b0, 1'b1, base + 16'h0002, 16'h0000);
      check({8'h00, q}, {16'h0000, ~page});
      bus(1'b0, A_LOW, 16'h0000);
      check({8'h00, q}, {8'h00, base + 16'h0002});
      bus(1'b0, A_UP, 16'h0000);
      check({8'h00, q}, {16'h0000, page});
      // Start without the key, without write enable, with the key broken, with a bad type.
      e = eraseCnt;
      for (int c = 0; c < 4; c++) begin
         wr(A_CON, 16'h0041);
         if (c > 0) wr(A_KEY, 16'h0055);
         if (c == 2) wr(A_LOW, base);
         if (c > 0) wr(A_KEY, 16'h00AA);
         wr(A_CON, (c == 1) ? 16'h8041 : (c == 3) ? 16'hC042 : 16'hC041);
         bus(1'b0, A_CON, 16'h0000);
         check({21'h0, q[15], q[13], cpuStall}, 24'h000002);
      end
      check(24'(eraseCnt - e), 24'h000000);
      // Erase a row aimed at by direct register writes; the core stalls meanwhile.
      wr(A_UP, {8'h00, page});
      wr(A_LOW, base);
      s = stallCnt;
      unlock();
      wr(A_CON, 16'hC041);
      tbl(1'b0, 1'b0, base, 16'h0000);
      check(24'(n > OPC), 24'h000001);
      check(24'(stallCnt - s), 24'(OPC));
      check(24'(eraseCnt - e), 24'h000001);
      bus(1'b0, A_CON, 16'h0000);
      check({23'h0, q[15]}, 24'h000000);
      for (int i = 0; i < 32; i++) img[i] = 24'hFFFFFF;
      row_check();
      // Latch load in row order; high writes carry a random unused upper byte.
      w = wordCnt;
      for (int i = 0; i < 32; i++) begin
         img[i] = 24'($random(seed));
         tbl(1'b1, 1'b0, base + 16'(2 * i), img[i][15:0]);
         check(24'(n), 24'h000002);
         tbl(1'b1, 1'b1, base + 16'(2 * i), {8'($random(seed)), img[i][23:16]});
      end
      check(24'(wordCnt - w + eraseCnt - e), 24'h000001);
      // Target in another panel is refused, then the proper target programs the row.
      wr(A_UP, {8'h00, page ^ 8'h01});
      unlock();
      wr(A_CON, 16'hC001);
      bus(1'b0, A_CON, 16'h0000);
      check({22'h0, q[15], q[13]}, 24'h000001);
      wr(A_UP, {8'h00, page});
      wr(A_LOW, base + 16'h003E);
      unlock();
      wr(A_CON, 16'hC001);
      tbl(1'b0, 1'b0, base, 16'h0000);
      check(24'(wordCnt - w), 24'd32);
      row_check();
      // Byte lanes: reload word zero a byte at a time, program the row again, read by bytes.
      tableByte <= 1'b1;
      img[0] = 24'($random(seed));
      tbl(1'b1, 1'b0, base + 16'h0001, {8'hFF, img[0][15:8]});
      tbl(1'b1, 1'b0, base, {8'hFF, img[0][7:0]});
      tbl(1'b1, 1'b1, base, {8'hFF, img[0][23:16]});
      tbl(1'b1, 1'b1, base + 16'h0001, 16'h00FF);
      unlock();
      wr(A_CON, 16'hC001);
      for (int b = 0; b < 4; b++) begin
         tbl(1'b0, 1'(b / 2), base + 16'(b % 2), 16'h0000);
         check({8'h00, q}, byte_exp(img[0], b));
      end
      give_verdict();
   end
endmodule : flash_self_program_ctrl_bench
